// file: bench/testbench.sv
// self-checking testbench for the switch global control register bank
`timescale 1ns/1ns
module testbench;
  // short storm period keeps the tick scenario brief
  localparam int FAST = 16;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic strap_in = 1'b0;
  logic vid_valid_in = 1'b0;
  logic [11:0] vid_in = 12'h000;
  logic [11:0] dflt_vid_in = 12'h123;
  logic [3:0] speed_10m_in = 4'h3;
  logic [3:0] link_in = 4'hF;
  logic [3:0] act_in = 4'h0;
  logic [3:0] spd_in = 4'h5;
  logic [3:0] fdx_in = 4'h3;
  logic [7:0] rdata;
  logic rvalid, vvalid, switch_mac_three, switch_mac_four, pwr, smi, led;
  logic [11:0] vid_out;
  logic [10:0] thr;
  logic [3:0] tick, led_a, led_b;
  int error_cnt = 0;
  int checked = 0;

  always #25 ref_clk_in = ~ref_clk_in;

  sgc_regs #(.NUM_PORTS(4), .FAST_PERIOD_CYCLES(FAST)) uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .port_four_rx_bit0_strap_in(strap_in),
    .vid_valid_in(vid_valid_in), .vid_in(vid_in), .port_default_vid_in(dflt_vid_in), .vid_valid_out(vvalid),
    .vid_out(vid_out), .port_speed_10m_in(speed_10m_in), .storm_threshold_out(thr), .storm_period_tick_out(tick),
    .link_in(link_in), .activity_in(act_in), .speed_100_in(spd_in), .full_duplex_in(fdx_in),
    .port_led_a_out(led_a), .port_led_b_out(led_b), .switch_mac_three_rx_negedge_out(switch_mac_three),
    .switch_mac_four_rx_negedge_out(switch_mac_four), .phy_power_save_out(pwr), .smi_read_edge_out(smi), .led_mode_out(led));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // reads one register and compares; a missing answer ends the run
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 8) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    if (n == 8) begin
      error_cnt++;
      final_report();
    end else begin
      check($sformatf("rdata@%0h", a), {8'h00, rdata}, {8'h00, exp});
    end
  endtask : rdchk

  task automatic t_reset;
    check("threshold", {5'h00, thr}, 16'h004A);
    rdchk(8'h06, 8'h00);
    rdchk(8'h07, 8'h4A);
    rdchk(8'h0B, 8'h00);
    rdchk(8'h0C, 8'h00);
  endtask : t_reset

  task automatic t_storm;
    wr(8'h06, 8'hFF);
    wr(8'h07, 8'h10);
    rdchk(8'h06, 8'h0F);
    rdchk(8'h07, 8'h10);
    check("threshold", {5'h00, thr}, 16'h0710);
  endtask : t_storm

  // writes to factory places must leave their fixed values
  task automatic t_factory;
    wr(8'h08, 8'hFF);
    wr(8'h09, 8'h00);
    wr(8'h0A, 8'hFF);
    rdchk(8'h08, 8'h00);
    rdchk(8'h09, 8'h4C);
    rdchk(8'h0A, 8'h00);
  endtask : t_factory

  task automatic t_ctl;
    wr(8'h0B, 8'hFF);
    rdchk(8'h0B, 8'hCB);
    check("ctl_set", {11'h000, switch_mac_three, switch_mac_four, pwr, led, smi}, 16'h001F);
    wr(8'h0B, 8'h00);
    @(posedge ref_clk_in);
    check("ctl_clr", {11'h000, switch_mac_three, switch_mac_four, pwr, led, smi}, 16'h0000);
  endtask : t_ctl

  task automatic vid_step(input logic [11:0] v, input logic [11:0] exp);
    @(posedge ref_clk_in);
    vid_valid_in <= 1'b1;
    vid_in <= v;
    @(posedge ref_clk_in);
    #1;
    check("vid", {3'h0, vvalid, vid_out}, {4'h1, exp});
  endtask : vid_step

  task automatic t_vid;
    wr(8'h06, 8'h00);
    vid_step(12'h000, 12'h000);
    wr(8'h06, 8'h08);
    vid_step(12'h000, 12'h123);
    vid_step(12'h055, 12'h055);
  endtask : t_vid

  task automatic t_led;
    wr(8'h0B, 8'h00);
    repeat (2) @(posedge ref_clk_in);
    check("led_m0", {8'h00, led_b, led_a}, 16'h00F5);
    wr(8'h0B, 8'h02);
    repeat (2) @(posedge ref_clk_in);
    check("led_m1", {8'h00, led_b, led_a}, 16'h0053);
  endtask : t_led

  // second reset with the strap pulled high: led mode must follow the pin
  task automatic t_strap;
    @(posedge ref_clk_in);
    strap_in <= 1'b1;
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    check("led_strap", {15'h0000, led}, 16'h0001);
    check("thr_rst", {5'h00, thr}, 16'h004A);
    rdchk(8'h0B, 8'h02);
  endtask : t_strap

  // any window of ten fast periods holds ten fast ticks and one slow tick
  task automatic t_tick;
    int fast_n;
    int slow_n;
    fast_n = 0;
    slow_n = 0;
    repeat (10 * FAST) begin
      @(posedge ref_clk_in);
      #1;
      if (tick[2] === 1'b1) fast_n++;
      if (tick[0] === 1'b1) slow_n++;
    end
    check("fast_ticks", 16'(fast_n), 16'd10);
    check("slow_ticks", 16'(slow_n), 16'd1);
  endtask : t_tick

  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    t_reset();
    t_storm();
    t_factory();
    t_ctl();
    t_vid();
    t_led();
    t_strap();
    t_tick();
    final_report();
  end
endmodule : testbench

// file: rtl/sgc_pkg.sv
// constants for the switch global control register bank
package sgc_pkg;
  // register offsets
  localparam logic [7:0] OFS_STORM_HIGH_VID = 8'h06;
  localparam logic [7:0] OFS_STORM_LOW = 8'h07;
  localparam logic [7:0] OFS_FACTORY_A = 8'h08;
  localparam logic [7:0] OFS_FACTORY_B = 8'h09;
  localparam logic [7:0] OFS_FACTORY_C = 8'h0A;
  localparam logic [7:0] OFS_CLK_LED_PWR = 8'h0B;
  // field positions
  localparam int BIT_NULL_VID = 3;
  localparam int BIT_STORM_HIGH_MSB = 2;
  localparam int BIT_SWITCH_MAC_THREE_EDGE = 7;
  localparam int BIT_SWITCH_MAC_FOUR_EDGE = 6;
  localparam int BIT_PHY_SAVE = 3;
  localparam int BIT_LED_MODE = 1;
  localparam int BIT_SMI_EDGE = 0;
  // reset values
  localparam logic [2:0] RST_STORM_HIGH = 3'h0;
  localparam logic [7:0] RST_STORM_LOW = 8'h4A;
  localparam logic [7:0] RST_FACTORY_A = 8'h00;
  localparam logic [7:0] RST_FACTORY_B = 8'h4C;
  localparam logic [7:0] RST_FACTORY_C = 8'h00;
  // widths
  localparam int VID_W = 12;
  localparam int STORM_W = 11;
  // storm period timing
  localparam longint CLK_HZ = 20000000;
  localparam longint PERIOD_FAST_MS = 50;
  localparam longint PERIOD_SLOW_MS = 500;
  localparam int PERIOD_FAST_CYCLES = int'(PERIOD_FAST_MS * CLK_HZ / 1000);
  localparam int PERIOD_SLOW_RATIO = int'(PERIOD_SLOW_MS / PERIOD_FAST_MS);
endpackage : sgc_pkg

// file: rtl/sgc_regs.sv
// switch global control registers with the logic they steer
`timescale 1ns/1ns
// Operation
// RULE1: null vlan identifier replaced by port default
// RULE2: eleven-bit storm threshold from two registers
// RULE3: storm period 50 ms fast, 500 ms slow
// RULE4: storm threshold resets to 0x04A
// RULE5: port three edge bit selects sampling edge
// RULE6: port four edge bit selects sampling edge
// RULE7: led mode strapped, selects led mapping
// RULE8: bit zero picks serial read edge
// RULE9: factory and reserved bits ignore writes
// RULE10: power save bit drives phy power saving
module sgc_regs #(
  parameter int NUM_PORTS = 4,
  parameter int FAST_PERIOD_CYCLES = sgc_pkg::PERIOD_FAST_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // register port from the serial management engine
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // strap pin
  input wire logic port_four_rx_bit0_strap_in,
  // tag path
  input wire logic vid_valid_in,
  input wire logic [sgc_pkg::VID_W-1:0] vid_in,
  input wire logic [sgc_pkg::VID_W-1:0] port_default_vid_in,
  output logic vid_valid_out,
  output logic [sgc_pkg::VID_W-1:0] vid_out,
  // storm protection
  input wire logic [NUM_PORTS-1:0] port_speed_10m_in,
  output logic [sgc_pkg::STORM_W-1:0] storm_threshold_out,
  output logic [NUM_PORTS-1:0] storm_period_tick_out,
  // port status for leds
  input wire logic [NUM_PORTS-1:0] link_in,
  input wire logic [NUM_PORTS-1:0] activity_in,
  input wire logic [NUM_PORTS-1:0] speed_100_in,
  input wire logic [NUM_PORTS-1:0] full_duplex_in,
  output logic [NUM_PORTS-1:0] port_led_a_out,
  output logic [NUM_PORTS-1:0] port_led_b_out,
  // control levels
  output logic switch_mac_three_rx_negedge_out,
  output logic switch_mac_four_rx_negedge_out,
  output logic phy_power_save_out,
  output logic smi_read_edge_out,
  output logic led_mode_out
);

  localparam int CNT_W = $clog2(FAST_PERIOD_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FAST_PERIOD_CYCLES - 1);
  localparam logic [3:0] SLOW_LAST = 4'(sgc_pkg::PERIOD_SLOW_RATIO - 1);

  // register state
  logic null_vid_replace;
  logic [2:0] storm_high;
  logic [7:0] storm_low;
  logic switch_mac_three_edge;
  logic switch_mac_four_edge;
  logic phy_save;
  logic led_mode;
  logic smi_edge;

  // strap capture
  logic strap_s1;
  logic strap_s2;
  // counts edges since release until the synchroniser holds the pin
  logic [1:0] strap_cnt;

  // period timer
  logic [CNT_W-1:0] period_cnt;
  logic [3:0] slow_cnt;

  function automatic logic [sgc_pkg::VID_W-1:0] replace_vid(input logic en,
      input logic [sgc_pkg::VID_W-1:0] rx, input logic [sgc_pkg::VID_W-1:0] dflt);
    replace_vid = (en && rx == '0) ? dflt : rx;
  endfunction : replace_vid

  // decode
  wire wr_high = reg_wr_in && reg_addr_in == sgc_pkg::OFS_STORM_HIGH_VID;
  wire wr_low = reg_wr_in && reg_addr_in == sgc_pkg::OFS_STORM_LOW;
  wire wr_ctl = reg_wr_in && reg_addr_in == sgc_pkg::OFS_CLK_LED_PWR;
  wire fast_tick = period_cnt == CNT_LAST;
  wire slow_tick = fast_tick && slow_cnt == SLOW_LAST;
  wire [NUM_PORTS-1:0] lnk_act = link_in & ~activity_in;
  wire [NUM_PORTS-1:0] next_led_b = led_mode ? (lnk_act & speed_100_in) : lnk_act; // [RULE7]
  wire [NUM_PORTS-1:0] next_led_a = led_mode ? full_duplex_in : speed_100_in; // [RULE7]
  wire [NUM_PORTS-1:0] next_tick = {NUM_PORTS{fast_tick}} & (~port_speed_10m_in | {NUM_PORTS{slow_tick}});
  wire [7:0] ctl_read = {switch_mac_three_edge, switch_mac_four_edge, 2'b00, phy_save, 1'b0, led_mode, smi_edge};

  // factory and reserved bits have no storage, so writes to them cannot land
  logic [7:0] next_rdata;
  always_comb begin
    unique case (reg_addr_in)
      sgc_pkg::OFS_STORM_HIGH_VID: next_rdata = {4'h0, null_vid_replace, storm_high};
      sgc_pkg::OFS_STORM_LOW: next_rdata = storm_low;
      sgc_pkg::OFS_FACTORY_A: next_rdata = sgc_pkg::RST_FACTORY_A; // [RULE9]
      sgc_pkg::OFS_FACTORY_B: next_rdata = sgc_pkg::RST_FACTORY_B; // [RULE9]
      sgc_pkg::OFS_FACTORY_C: next_rdata = sgc_pkg::RST_FACTORY_C; // [RULE9]
      sgc_pkg::OFS_CLK_LED_PWR: next_rdata = ctl_read;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      null_vid_replace <= 1'b0;
      storm_high <= sgc_pkg::RST_STORM_HIGH; // [RULE4]
      storm_low <= sgc_pkg::RST_STORM_LOW; // [RULE4]
    end else begin
      if (wr_high) begin
        null_vid_replace <= reg_wdata_in[sgc_pkg::BIT_NULL_VID];
        storm_high <= reg_wdata_in[sgc_pkg::BIT_STORM_HIGH_MSB:0]; // [RULE2]
      end
      if (wr_low) begin
        storm_low <= reg_wdata_in; // [RULE2]
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      switch_mac_three_edge <= 1'b0;
      switch_mac_four_edge <= 1'b0;
      phy_save <= 1'b0;
      smi_edge <= 1'b0;
    end else if (wr_ctl) begin
      switch_mac_three_edge <= reg_wdata_in[sgc_pkg::BIT_SWITCH_MAC_THREE_EDGE]; // [RULE5]
      switch_mac_four_edge <= reg_wdata_in[sgc_pkg::BIT_SWITCH_MAC_FOUR_EDGE]; // [RULE6]
      phy_save <= reg_wdata_in[sgc_pkg::BIT_PHY_SAVE]; // [RULE10]
      smi_edge <= reg_wdata_in[sgc_pkg::BIT_SMI_EDGE]; // [RULE8]
    end
  end

  // the strap is caught once, at the third edge after release, when the second flop
  // finally holds the pin; earlier loads would only see the reset zero of the chain.
  // a write in that same cycle loses to it
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_cnt <= 2'h0;
      led_mode <= 1'b0;
    end else begin
      strap_s1 <= port_four_rx_bit0_strap_in;
      strap_s2 <= strap_s1;
      if (strap_cnt != 2'h3) begin
        strap_cnt <= strap_cnt + 2'h1;
      end
      if (strap_cnt == 2'h2) begin
        led_mode <= strap_s2; // [RULE7]
      end else if (wr_ctl) begin
        led_mode <= reg_wdata_in[sgc_pkg::BIT_LED_MODE]; // [RULE7]
      end
    end
  end

  // one base timer serves every port; slow ports take every tenth fast tick
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      period_cnt <= '0;
      slow_cnt <= 4'h0;
      storm_period_tick_out <= '0;
    end else begin
      period_cnt <= fast_tick ? '0 : period_cnt + 1'b1; // [RULE3]
      if (fast_tick) begin
        slow_cnt <= slow_tick ? 4'h0 : slow_cnt + 4'h1; // [RULE3]
      end
      storm_period_tick_out <= next_tick; // [RULE3]
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vid_valid_out <= 1'b0;
      vid_out <= '0;
      port_led_a_out <= '0;
      port_led_b_out <= '0;
    end else begin
      vid_valid_out <= vid_valid_in;
      vid_out <= replace_vid(null_vid_replace, vid_in, port_default_vid_in); // [RULE1]
      port_led_a_out <= next_led_a;
      port_led_b_out <= next_led_b;
    end
  end

  assign storm_threshold_out = {storm_high, storm_low}; // [RULE2]
  assign switch_mac_three_rx_negedge_out = switch_mac_three_edge; // [RULE5]
  assign switch_mac_four_rx_negedge_out = switch_mac_four_edge; // [RULE6]
  assign phy_power_save_out = phy_save; // [RULE10]
  assign smi_read_edge_out = smi_edge; // [RULE8]
  assign led_mode_out = led_mode;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  chk_vid_replace: assert property (vid_valid_in && vid_in == '0 && null_vid_replace |=> // [RULE1]
      vid_out == $past(port_default_vid_in)) else $error("null vid not replaced");
  chk_vid_keep: assert property (vid_valid_in && !null_vid_replace |=> vid_out == $past(vid_in)) // [RULE1]
    else $error("vid altered while replacement off");
  chk_storm_low_write: assert property (wr_low |=> storm_threshold_out[7:0] == $past(reg_wdata_in)) // [RULE2]
    else $error("storm low byte not written");
  chk_storm_high_write: assert property (wr_high |=> storm_threshold_out[10:8] == $past(reg_wdata_in[2:0])) // [RULE2]
    else $error("storm high bits not written");
  chk_slow_tick_rate: assert property (slow_tick |-> fast_tick && slow_cnt == SLOW_LAST) // [RULE3]
    else $error("slow tick off the fast grid");
  chk_fast_tick_gap: assert property (fast_tick |=> !fast_tick [*2]) // [RULE3]
    else $error("fast ticks too close");
  chk_tick_speed: assert property (fast_tick && !slow_tick && port_speed_10m_in[0] |=> !storm_period_tick_out[0]) // [RULE3]
    else $error("slow port ticked at fast rate");
  chk_storm_reset: assert property ($fell(rst_in) |-> storm_threshold_out == 11'h04A) // [RULE4]
    else $error("storm threshold reset wrong");
  chk_switch_mac_three_edge: assert property (wr_ctl |=> switch_mac_three_rx_negedge_out == $past(reg_wdata_in[7])) // [RULE5]
    else $error("port three edge not updated");
  chk_switch_mac_four_edge: assert property (wr_ctl |=> switch_mac_four_rx_negedge_out == $past(reg_wdata_in[6])) // [RULE6]
    else $error("port four edge not updated");
  chk_led_strap: assert property (strap_cnt == 2'h2 |=> led_mode_out == $past(strap_s2)) // [RULE7]
    else $error("led mode not strapped");

  chk_led_map: assert property (led_mode && full_duplex_in[0] |=> port_led_a_out[0]) // [RULE7]
    else $error("mode one duplex led wrong");

  chk_smi_edge: assert property (wr_ctl ##1 !wr_ctl [*2] |-> smi_read_edge_out == $past(reg_wdata_in[0], 2)) // [RULE8]
    else $error("read edge bit not held");

  chk_factory_fixed: assert property (reg_rd_in && reg_addr_in == sgc_pkg::OFS_FACTORY_B |=> reg_rdata_out == 8'h4C) // [RULE9]
    else $error("factory register changed");

  chk_power_save: assert property (wr_ctl |=> phy_power_save_out == $past(reg_wdata_in[3])) // [RULE10]
    else $error("power save not updated");

  chk_rvalid_pulse: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read answer missing");

  chk_rvalid_idle: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("read answer without request");

  chk_read_low: assert property (reg_rd_in && reg_addr_in == sgc_pkg::OFS_STORM_LOW |=> // [RULE2]
      reg_rdata_out == storm_threshold_out[7:0]) else $error("storm low byte read wrong");

  chk_factory_a: assert property (reg_rd_in && reg_addr_in == sgc_pkg::OFS_FACTORY_A |=> reg_rdata_out == 8'h00) // [RULE9]
    else $error("factory register a changed");

  chk_factory_c: assert property (reg_rd_in && reg_addr_in == sgc_pkg::OFS_FACTORY_C |=> reg_rdata_out == 8'h00) // [RULE9]
    else $error("factory register c changed");

  chk_ctl_reserved: assert property (reg_rd_in && reg_addr_in == sgc_pkg::OFS_CLK_LED_PWR |=> // [RULE9]
      (reg_rdata_out & 8'h34) == 8'h00) else $error("reserved control bits read set");

  chk_high_reserved: assert property (reg_rd_in && reg_addr_in == sgc_pkg::OFS_STORM_HIGH_VID |=> // [RULE9]
      reg_rdata_out[7:4] == 4'h0) else $error("reserved high bits read set");

  chk_led_mode0: assert property (!led_mode && speed_100_in[0] |=> port_led_a_out[0]) // [RULE7]
    else $error("mode zero speed led wrong");

  chk_led_b_mode0: assert property (!led_mode && link_in[0] && !activity_in[0] |=> port_led_b_out[0]) // [RULE7]
    else $error("mode zero link led wrong");

  chk_led_b_mode1: assert property (led_mode && !speed_100_in[0] |=> !port_led_b_out[0]) // [RULE7]
    else $error("mode one link led lit at low speed");

  chk_tick_fast_port: assert property (fast_tick && !port_speed_10m_in[2] |=> storm_period_tick_out[2]) // [RULE3]
    else $error("fast port missed its tick");

  chk_tick_only_base: assert property (!fast_tick |=> storm_period_tick_out == '0) // [RULE3]
    else $error("tick off the base timer");

  chk_vid_valid: assert property (vid_valid_in |=> vid_valid_out) // [RULE1]
    else $error("vid valid lost");

  chk_ctl_hold: assert property (!wr_ctl |=> $stable(phy_power_save_out)) // [RULE10]
    else $error("power save moved without write");

  chk_storm_hold: assert property (!wr_high && !wr_low |=> $stable(storm_threshold_out)) // [RULE2]
    else $error("storm threshold moved without write");

  chk_mac_hold: assert property (!wr_ctl |=> $stable(switch_mac_three_rx_negedge_out)) // [RULE5]
    else $error("port three edge moved without write");

endmodule : sgc_regs
